// *** hw/mafl_alert.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - power above limit asserts alert when power over-limit enable set
// - conversion-done alert enable asserts alert when done flag sets
// - one limit function drives alert; conversion-done may add to it
// - latched limit-hit flag clears only on a mask/flags register read
// - transparent limit-hit clears after a later conversion with no alert
// - done flag sets only after conversions, averaging, multiplications finish
// - single-shot: done flag clears on non-off config write or mask read
// - math overflow sets overflow flag marking results possibly invalid
// - sense-invert bit 1 active-high output, 0 active-low default
// - latch bit 1 latches output and flags, 0 transparent default
// - transparent: output and flags idle once fault is gone
// - latched: output and flags stay active until mask/flags read
// - highest enabled bit among 15..11 chooses compared measurement
// - shunt over/under enables compare shunt result above/below limit
// - bus over/under enables compare bus result above/below limit
// - separate 16-bit limit register holds compared value
module mafl_alert (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // register access from the serial interface
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  // conversion engine
  input  wire logic        i_conv_done,
  input  wire logic        i_math_ovf,
  input  wire logic [15:0] i_shunt_val,
  input  wire logic [15:0] i_bus_val,
  input  wire logic [15:0] i_power_val,
  // open-drain alert pin
  output logic             o_alert_out,
  output logic             o_alert_oe_n
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] limit_r, limit_nxt;
  logic        limit_hit_flag_r, limit_hit_flag_nxt;
  logic        conv_done_flag_r, conv_done_flag_nxt;
  logic        math_overflow_flag_r, math_overflow_flag_nxt;
  logic        cont_mode_r, cont_mode_nxt;
  logic        cmp_hit;
  logic        mask_rd;
  logic        cfg_wr;
  logic        alert_act;

  // signed compare used by the shunt and bus limit tests
  function automatic logic above(input logic [15:0] a, input logic [15:0] b);
    above = $signed(a) > $signed(b);
  endfunction

  // --------------------------------------------------------------------------
  // limit comparison, highest enable wins
  // --------------------------------------------------------------------------
  always_comb begin
    cmp_hit = 1'b0;
    if (ctrl_r[mafl_pkg::SHUNT_OVER_BIT]) begin
      cmp_hit = above(i_shunt_val, limit_r);
    end else if (ctrl_r[mafl_pkg::SHUNT_UNDER_BIT]) begin
      cmp_hit = above(limit_r, i_shunt_val);
    end else if (ctrl_r[mafl_pkg::BUS_OVER_BIT]) begin
      cmp_hit = above(i_bus_val, limit_r);
    end else if (ctrl_r[mafl_pkg::BUS_UNDER_BIT]) begin
      cmp_hit = above(limit_r, i_bus_val);
    end else if (ctrl_r[mafl_pkg::POWER_OVER_BIT]) begin
      cmp_hit = i_power_val > limit_r; // power is unsigned
    end
  end

  assign mask_rd = i_reg_rd && (i_reg_addr == mafl_pkg::MASK_FLAGS_OFS);
  assign cfg_wr  = i_reg_wr && (i_reg_addr == mafl_pkg::CONFIG_OFS);

  // --------------------------------------------------------------------------
  // next values of registers and flags; a set beats a same-cycle clear
  // --------------------------------------------------------------------------
  always_comb begin
    ctrl_nxt               = ctrl_r;
    limit_nxt              = limit_r;
    cont_mode_nxt          = cont_mode_r;
    limit_hit_flag_nxt     = limit_hit_flag_r;
    conv_done_flag_nxt     = conv_done_flag_r;
    math_overflow_flag_nxt = math_overflow_flag_r;
    if (i_reg_wr && i_reg_addr == mafl_pkg::MASK_FLAGS_OFS) begin
      ctrl_nxt = i_reg_wdata & mafl_pkg::CTRL_WR_MASK;
    end else if (i_reg_wr && i_reg_addr == mafl_pkg::ALERT_LIMIT_OFS) begin
      limit_nxt = i_reg_wdata;
    end
    if (cfg_wr) begin
      cont_mode_nxt = i_reg_wdata[mafl_pkg::MODE_CONT_BIT];
    end
    // limit-hit flag: latched clears by read only, transparent by clean result
    if (ctrl_r[mafl_pkg::LATCH_BIT]) begin
      if (mask_rd) begin
        limit_hit_flag_nxt = 1'b0;
      end
      if (i_conv_done && cmp_hit) begin
        limit_hit_flag_nxt = 1'b1;
      end
    end else if (i_conv_done) begin
      limit_hit_flag_nxt = cmp_hit;
    end
    // done flag: single-shot clears on read or non-off config write
    if (mask_rd || (cfg_wr && !cont_mode_r && i_reg_wdata[2:0] != mafl_pkg::MODE_OFF_A
        && i_reg_wdata[2:0] != mafl_pkg::MODE_OFF_B)) begin
      conv_done_flag_nxt = 1'b0;
    end
    if (i_conv_done) begin
      conv_done_flag_nxt = 1'b1; // engine pulses only after all math
    end
    // overflow flag follows fault when transparent, holds when latched
    if (!ctrl_r[mafl_pkg::LATCH_BIT] && i_conv_done) begin
      math_overflow_flag_nxt = i_math_ovf;
    end else if (mask_rd && ctrl_r[mafl_pkg::LATCH_BIT]) begin
      math_overflow_flag_nxt = 1'b0;
    end
    if (i_math_ovf) begin
      math_overflow_flag_nxt = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // register stage
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r               <= mafl_pkg::MASK_FLAGS_RST;
      limit_r              <= mafl_pkg::ALERT_LIMIT_RST;
      cont_mode_r          <= mafl_pkg::CONT_MODE_RST;
      limit_hit_flag_r     <= 1'b0;
      conv_done_flag_r     <= 1'b0;
      math_overflow_flag_r <= 1'b0;
    end else begin
      ctrl_r               <= ctrl_nxt;
      limit_r              <= limit_nxt;
      cont_mode_r          <= cont_mode_nxt;
      limit_hit_flag_r     <= limit_hit_flag_nxt;
      conv_done_flag_r     <= conv_done_flag_nxt;
      math_overflow_flag_r <= math_overflow_flag_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // read data and alert pin
  // --------------------------------------------------------------------------
  always_comb begin
    o_reg_rdata = 16'h0000;
    if (i_reg_addr == mafl_pkg::MASK_FLAGS_OFS) begin
      o_reg_rdata = ctrl_r;
      o_reg_rdata[mafl_pkg::LIMIT_HIT_BIT] = limit_hit_flag_r;
      o_reg_rdata[mafl_pkg::CONV_DONE_BIT] = conv_done_flag_r;
      o_reg_rdata[mafl_pkg::OVERFLOW_BIT]  = math_overflow_flag_r;
    end else if (i_reg_addr == mafl_pkg::ALERT_LIMIT_OFS) begin
      o_reg_rdata = limit_r;
    end
  end

  // alert active from flags only, so latching follows the flags directly
  assign alert_act = limit_hit_flag_r
    || (ctrl_r[mafl_pkg::CONV_ALERT_BIT] && conv_done_flag_r);
  // pin is driven low when active with sense bit 0 or idle with sense bit 1, else released
  assign o_alert_out  = 1'b0;
  assign o_alert_oe_n = ~(alert_act ^ ctrl_r[mafl_pkg::SENSE_INV_BIT]);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  // most look one edge past the cause, so a same-cycle set still wins
  sequence s_hit_seen;
    ctrl_r[mafl_pkg::LATCH_BIT] && i_conv_done && cmp_hit;
  endsequence
  sequence s_quiet;
    !mask_rd && !i_conv_done;
  endsequence

  a_latched_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (ctrl_r[mafl_pkg::LATCH_BIT] && limit_hit_flag_r && !mask_rd) |=> limit_hit_flag_r)
    else $error("latched flag dropped without read");
  a_latch_stick: assert property (@(posedge i_clk) disable iff (i_rst)
    s_hit_seen ##1 s_quiet [*2] |=> limit_hit_flag_r)
    else $error("latched flag lost after quiet cycles");
  a_latch_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (ctrl_r[mafl_pkg::LATCH_BIT] && mask_rd && !i_conv_done) |=> !limit_hit_flag_r)
    else $error("latched flag not cleared by read");
  a_trans_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    (!ctrl_r[mafl_pkg::LATCH_BIT] && i_conv_done) |=> (limit_hit_flag_r == $past(cmp_hit)))
    else $error("transparent flag not following result");
  a_done_set: assert property (@(posedge i_clk) disable iff (i_rst)
    i_conv_done |=> conv_done_flag_r)
    else $error("done flag not set");
  a_done_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (mask_rd && !i_conv_done) |=> !conv_done_flag_r)
    else $error("done flag not cleared by read");
  a_cfg_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (cfg_wr && !cont_mode_r && i_reg_wdata[1:0] != 2'h0 && !i_conv_done)
      |=> !conv_done_flag_r)
    else $error("done flag not cleared by config write");
  a_ovf_set: assert property (@(posedge i_clk) disable iff (i_rst)
    i_math_ovf |=> math_overflow_flag_r)
    else $error("overflow flag not set");
  a_ovf_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    (!ctrl_r[mafl_pkg::LATCH_BIT] && i_conv_done) |=> (math_overflow_flag_r == $past(i_math_ovf)))
    else $error("transparent overflow flag not following");
  a_ovf_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (ctrl_r[mafl_pkg::LATCH_BIT] && mask_rd && !i_math_ovf) |=> !math_overflow_flag_r)
    else $error("latched overflow flag not cleared by read");
  a_pin_sense: assert property (@(posedge i_clk) disable iff (i_rst)
    o_alert_oe_n == !((limit_hit_flag_r || (ctrl_r[mafl_pkg::CONV_ALERT_BIT]
      && conv_done_flag_r)) ^ ctrl_r[mafl_pkg::SENSE_INV_BIT]))
    else $error("alert pin sense wrong");
  a_conv_alert: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_conv_done && ctrl_r[mafl_pkg::CONV_ALERT_BIT] && !ctrl_r[mafl_pkg::SENSE_INV_BIT]
      && !(i_reg_wr && i_reg_addr == mafl_pkg::MASK_FLAGS_OFS)) |=> !o_alert_oe_n)
    else $error("conversion alert missing");
endmodule // mafl_alert
`default_nettype wire

// *** hw/mafl_pkg.sv ***
`default_nettype none
package mafl_pkg;
  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0]  MASK_FLAGS_OFS  = 8'h06;
  localparam logic [7:0]  ALERT_LIMIT_OFS = 8'h07;
  localparam logic [7:0]  CONFIG_OFS      = 8'h00;

  // --------------------------------------------------------------------------
  // field positions of the alert mask and flags register
  // --------------------------------------------------------------------------
  localparam int unsigned SHUNT_OVER_BIT  = 15;
  localparam int unsigned SHUNT_UNDER_BIT = 14;
  localparam int unsigned BUS_OVER_BIT    = 13;
  localparam int unsigned BUS_UNDER_BIT   = 12;
  localparam int unsigned POWER_OVER_BIT  = 11;
  localparam int unsigned CONV_ALERT_BIT  = 10;
  localparam int unsigned LIMIT_HIT_BIT   = 4;
  localparam int unsigned CONV_DONE_BIT   = 3;
  localparam int unsigned OVERFLOW_BIT    = 2;
  localparam int unsigned SENSE_INV_BIT   = 1;
  localparam int unsigned LATCH_BIT       = 0;

  // --------------------------------------------------------------------------
  // reset values and operating-mode field
  // --------------------------------------------------------------------------
  localparam logic [15:0] MASK_FLAGS_RST  = 16'h0000;
  localparam logic [15:0] ALERT_LIMIT_RST = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK    = 16'hFC03;
  localparam logic [2:0]  MODE_OFF_A      = 3'h0;
  localparam logic [2:0]  MODE_OFF_B      = 3'h4;
  localparam int unsigned MODE_CONT_BIT   = 2;
  localparam logic        CONT_MODE_RST   = 1'b1;
endpackage
`default_nettype wire

// *** test/mafl_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// -----------------------------
// host side of the alert pin
// -----------------------------
module mafl_host_model (
  // open-drain halves from the device
  input  wire logic i_alert_out,
  input  wire logic i_alert_oe_n,
  // wire level the host sees
  output logic      o_pin_level
);
  // pull-up wins once the device lets go, so a released pin never reads as driven
  assign o_pin_level = i_alert_oe_n ? 1'b1 : i_alert_out;
endmodule // mafl_host_model
`default_nettype wire

// *** test/tb_monitor_alert_flag_logic.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_monitor_alert_flag_logic;
  logic        clk, rst, wr, rd, conv, movf, pin, out, oe_n, m_hit, m_done, m_ovf, m_cont;
  logic [7:0]  addr;
  logic [15:0] wd, rdata, sh, bu, pw, m_mask, m_lim;
  int          miscompares, check_count, k;

  // -----------------------------
  // design and host
  // -----------------------------
  mafl_alert mafl_alert_inst (.i_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_conv_done(conv),
    .i_math_ovf(movf), .i_shunt_val(sh), .i_bus_val(bu), .i_power_val(pw),
    .o_alert_out(out), .o_alert_oe_n(oe_n));
  mafl_host_model mafl_host_model_inst (.i_alert_out(out), .i_alert_oe_n(oe_n),
    .o_pin_level(pin));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // highest enable wins; voltages signed, power unsigned
  function automatic logic hit_now();
    if (m_mask[15]) return $signed(sh) > $signed(m_lim);
    if (m_mask[14]) return $signed(sh) < $signed(m_lim);
    if (m_mask[13]) return $signed(bu) > $signed(m_lim);
    if (m_mask[12]) return $signed(bu) < $signed(m_lim);
    return m_mask[11] && (pw > m_lim);
  endfunction

  // level on the wire: low when active unless inverted
  function automatic logic exp_pin();
    return ~((m_hit | (m_mask[10] & m_done)) ^ m_mask[1]);
  endfunction

  // what a read of each address should return; unmapped reads give zero
  function automatic logic [15:0] exp_rd(input logic [7:0] a);
    if (a == 8'h06) return {m_mask[15:10], 5'h00, m_hit, m_done, m_ovf, m_mask[1:0]};
    if (a == 8'h07) return m_lim;
    return 16'h0000;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one cycle of stimulus; e puts every measurement exactly on the limit
  task automatic op(input logic w, r, c, e, input logic [7:0] a, input logic [15:0] d);
    {wr, rd, conv, addr, wd} = {w, r, c, a, d};
    movf = c & 1'($urandom_range(1));
    {sh, bu, pw} = e ? {m_lim, m_lim, m_lim} : {16'($urandom), 16'($urandom), 16'($urandom)};
    @(posedge clk);
    // reference update: clears first, so a same-cycle set wins
    if (r && a == 8'h06) begin
      m_done = 1'b0;
      if (m_mask[0]) {m_hit, m_ovf} = 2'h0;
    end
    if (w && a == 8'h06) m_mask = d & 16'hFC03;
    if (w && a == 8'h07) m_lim = d;
    // config write clears only when the stored mode was single-shot
    if (w && a == 8'h00) begin
      if (!m_cont && d[1:0] != 2'h0) m_done = 1'b0;
      m_cont = d[2];
    end
    if (c) begin
      m_hit = hit_now() | (m_mask[0] & m_hit);
      m_ovf = movf | (m_mask[0] & m_ovf);
      m_done = 1'b1;
    end
    // inputs stand until the next call replaces them, always two steps past the edge
    #1 chk(rdata, exp_rd(a));
    chk({15'h0000, pin}, {15'h0000, exp_pin()});
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // -----------------------------
  // main sequence
  // -----------------------------
  initial begin
    {rst, wr, rd, conv, movf, addr, wd, sh, bu, pw} = {5'h10, 8'h06, 64'h0};
    {m_mask, m_lim, m_hit, m_done, m_ovf} = 35'h0;
    {miscompares, check_count} = {32'd0, 32'd0};
    void'($urandom(32'hE0E0A02C));
    m_cont = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(rdata, 16'h0000);
    chk({15'h0000, pin}, 16'h0001);
    #1 rst = 1'b0;
    $display("test reset done");
    // single-shot until random config writes change it, so done-flag clearing is well defined
    op(1, 0, 0, 0, 8'h00, 16'h0000);
    // each comparator alone: random, then exactly on the limit, latched for odd bits, transparent for even
    for (int b = 11; b < 16; b++) begin
      op(1, 0, 0, 0, 8'h06, (16'h0001 << b) | 16'(b & 1));
      op(1, 0, 0, 0, 8'h07, 16'h0100);
      repeat (3) op(0, 0, 1, 0, 8'h06, 16'h0000);
      op(0, 0, 1, 1, 8'h06, 16'h0000);
      op(0, 1, 0, 0, 8'h06, 16'h0000);
    end
    $display("test comparators done");
    // all enables, inverted, latched; read colliding with a conversion
    op(1, 0, 0, 0, 8'h06, 16'hFC03);
    op(0, 0, 1, 0, 8'h06, 16'h0000);
    op(0, 1, 1, 0, 8'h06, 16'h0000);
    op(1, 0, 0, 0, 8'h08, 16'hFFFF);
    op(0, 0, 0, 0, 8'h07, 16'h0000);
    $display("test priority done");
    repeat (600) begin
      k = $urandom_range(5);
      case (k)
        0: op(1, 0, 0, 0, 8'h06, 16'($urandom));
        1: op(1, 0, 0, 0, 8'h07, 16'($urandom));
        2: op(1, 0, 1'($urandom_range(1)), 0, 8'h00, 16'($urandom));
        3: op(0, m_mask[0], 1'($urandom_range(1)), 0, 8'h06, 16'h0000);
        default: op(0, 0, 1, $urandom_range(3) == 0, 8'h06, 16'h0000);
      endcase
    end
    $display("test random done");
    // reset in mid-run: back to continuous mode, where config writes keep the flag
    {wr, rd, conv, movf, addr} = {4'h0, 8'h06};
    rst = 1'b1;
    #1 chk(rdata, 16'h0000);
    chk({15'h0000, pin}, 16'h0001);
    @(posedge clk);
    #2 rst = 1'b0;
    {m_mask, m_lim, m_hit, m_done, m_ovf} = 35'h0;
    m_cont = 1'b1;
    op(0, 0, 1, 0, 8'h06, 16'h0000);
    op(1, 0, 0, 0, 8'h00, 16'h0003);
    op(0, 0, 0, 0, 8'h06, 16'h0000);
    $display("test reset again done");
    report_and_stop();
  end
endmodule // tb_monitor_alert_flag_logic
`default_nettype wire
